//--- hw/pin_mux_pkg.sv
// package of constants for the test port and reset pin mux
package pin_mux_pkg;
    // reset stretch after pin release, in system clocks
    localparam int RESET_STRETCH_CYCLES = 16;
    localparam int RESET_COUNT_WIDTH    = 5;
    // pin indices within the port d group
    localparam int PD_DATA_IN  = 0;
    localparam int PD_DATA_OUT = 1;
    localparam int PD_TEST_CLK = 2;
    localparam int PD_MODE_SEL = 3;
    localparam int PD_RESET    = 4;
    localparam int PORT_D_WIDTH = 5;
    localparam int PORT_A_WIDTH = 3;
    localparam int PA_CMP_PIN   = 0;
    localparam int PA_REF_PIN   = 2;
    // peripheral select code for the alternate function
    localparam logic [1:0] SELECT_ALT = 2'h1;
    // test access port states
    typedef enum logic [3:0] {
        TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_type;
endpackage

//--- hw/test_port_and_reset_pin_mux.sv
// pin mux for the test port, reset pin and first analog port pins
// Functional notes
// - sample data and mode inputs on rising clock
// - drive data out only in shift states
// - change data out on falling clock edge
// - low reset pin resets the device
// - release internal reset after fixed clock count
// - reset pin ignored in general purpose mode
// - primary functions selected after reset
// - alternate function carries comparator c output
// - converter control bit picks channel or reference
// - alternate needs enable and select both set
`timescale 1ns/1ps
`default_nettype none
module test_port_and_reset_pin_mux #(
    parameter int STRETCH = pin_mux_pkg::RESET_STRETCH_CYCLES
) (
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    input  wire logic                                   clkEn,
    input  wire logic                                   testClk,
    input  wire logic                                   powerOnResetN,
    input  wire logic                                   watchdog_reset_source,
    input  wire logic                                   softwareReset,
    input  wire logic [pin_mux_pkg::PORT_D_WIDTH-1:0]   portDPeripheralEnable,
    input  wire logic [pin_mux_pkg::PORT_D_WIDTH*2-1:0] portDSelect,
    input  wire logic [pin_mux_pkg::PORT_D_WIDTH-1:0]   portDOut,
    input  wire logic [pin_mux_pkg::PORT_D_WIDTH-1:0]   portDDir,
    input  wire logic [pin_mux_pkg::PORT_A_WIDTH-1:0]   portAPeripheralEnable,
    input  wire logic [pin_mux_pkg::PORT_A_WIDTH*2-1:0] portASelect,
    input  wire logic [pin_mux_pkg::PORT_A_WIDTH-1:0]   portAOut,
    input  wire logic [pin_mux_pkg::PORT_A_WIDTH-1:0]   portADir,
    input  wire logic                                   comparator_c_output,
    input  wire logic                                   converterRefSelect,
    input  wire logic                                   testDataReturn,
    input  wire logic [pin_mux_pkg::PORT_D_WIDTH-1:0]   port_d_pin_in,
    output logic      [pin_mux_pkg::PORT_D_WIDTH-1:0]   port_d_pin_out,
    output logic      [pin_mux_pkg::PORT_D_WIDTH-1:0]   port_d_pin_oe,
    input  wire logic [pin_mux_pkg::PORT_A_WIDTH-1:0]   port_a_pin_in,
    output logic      [pin_mux_pkg::PORT_A_WIDTH-1:0]   port_a_pin_out,
    output logic      [pin_mux_pkg::PORT_A_WIDTH-1:0]   port_a_pin_oe,
    output logic      [pin_mux_pkg::PORT_D_WIDTH-1:0]   portDIn,
    output logic      [pin_mux_pkg::PORT_A_WIDTH-1:0]   portAIn,
    output logic                                        converter_a_channel2_in,
    output logic                                        converter_a_ref_high,
    output logic                                        testDataSample,
    output logic                                        testModeSample,
    output logic                                        tapShifting,
    output logic                                        internalResetN
);
    import pin_mux_pkg::*;

    // ************************************************************
    // function selection
    // ************************************************************
    function automatic logic isAlt(input logic en, input logic [1:0] sel);
        isAlt = en && (sel == SELECT_ALT);
    endfunction

    // primary (test/reset) function is used unless enable is set with the alternate select code; reset clears via host registers
    logic [PORT_D_WIDTH-1:0] dGpio;
    logic [PORT_A_WIDTH-1:0] aAlt;
    genvar g;
    generate
        for (g = 0; g < PORT_D_WIDTH; g++) begin : gen_d
            assign dGpio[g] = isAlt(portDPeripheralEnable[g], portDSelect[2*g+1:2*g]);
        end
        for (g = 0; g < PORT_A_WIDTH; g++) begin : gen_a
            assign aAlt[g] = isAlt(portAPeripheralEnable[g], portASelect[2*g+1:2*g]);
        end
    endgenerate

    // ************************************************************
    // test port, clocked by the host's test clock
    // ************************************************************
    // repurposed pins feed the pulled-up high so the state machine parks
    logic tdiLevel;
    logic tmsLevel;
    assign tdiLevel = dGpio[PD_DATA_IN] ? 1'b1 : port_d_pin_in[PD_DATA_IN];
    assign tmsLevel = dGpio[PD_MODE_SEL] ? 1'b1 : port_d_pin_in[PD_MODE_SEL];

    tap_state_type tap_reg, tap_next;
    logic          tdi_reg, tms_reg, tdo_reg, tdo_next, drive_reg, drive_next;

    always_comb begin
        tap_next = tap_reg;
        unique case (tap_reg)
            TEST_RESET: tap_next = tmsLevel ? TEST_RESET : RUN_IDLE;
            RUN_IDLE:   tap_next = tmsLevel ? SEL_DR : RUN_IDLE;
            SEL_DR:     tap_next = tmsLevel ? SEL_IR : CAP_DR;
            CAP_DR:     tap_next = tmsLevel ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:   tap_next = tmsLevel ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:   tap_next = tmsLevel ? UPD_DR : PAUSE_DR;
            PAUSE_DR:   tap_next = tmsLevel ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:   tap_next = tmsLevel ? UPD_DR : SHIFT_DR;
            UPD_DR:     tap_next = tmsLevel ? SEL_DR : RUN_IDLE;
            SEL_IR:     tap_next = tmsLevel ? TEST_RESET : CAP_IR;
            CAP_IR:     tap_next = tmsLevel ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:   tap_next = tmsLevel ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:   tap_next = tmsLevel ? UPD_IR : PAUSE_IR;
            PAUSE_IR:   tap_next = tmsLevel ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:   tap_next = tmsLevel ? UPD_IR : SHIFT_IR;
            UPD_IR:     tap_next = tmsLevel ? SEL_DR : RUN_IDLE;
        endcase
        drive_next = (tap_reg == SHIFT_DR) || (tap_reg == SHIFT_IR);
        tdo_next   = testDataReturn;
    end

    // the test clock is gated by the host; nothing here needs an edge between frames
    always_ff @(posedge testClk or negedge rstn) begin
        if (!rstn) begin
            tap_reg <= TEST_RESET;
            tdi_reg <= 1'b1;
            tms_reg <= 1'b1;
        end else begin
            tap_reg <= tap_next;
            tdi_reg <= tdiLevel;
            tms_reg <= tmsLevel;
        end
    end

    always_ff @(negedge testClk or negedge rstn) begin
        if (!rstn) begin
            tdo_reg   <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            tdo_reg   <= tdo_next;
            drive_reg <= drive_next;
        end
    end

    assign testDataSample = tdi_reg;
    assign testModeSample = tms_reg;
    assign tapShifting    = drive_reg;

    // ************************************************************
    // reset pin filter and stretch, system clock
    // ************************************************************
    logic [2:0] rstSync_reg, rstSync_next;
    logic       pinLevel_reg, pinLevel_next;
    logic [RESET_COUNT_WIDTH-1:0] cnt_reg, cnt_next;
    logic       irst_reg, irst_next;
    logic       pinResetReq;

    always_comb begin
        rstSync_next  = {rstSync_reg[1:0], port_d_pin_in[PD_RESET]};
        pinLevel_next = (rstSync_reg[2] == rstSync_reg[1]) ? rstSync_reg[1] : pinLevel_reg;
        pinResetReq   = !pinLevel_reg && !dGpio[PD_RESET];
        if (pinResetReq || watchdog_reset_source || softwareReset) begin
            cnt_next  = '0;
            irst_next = 1'b0;
        end else if (cnt_reg != RESET_COUNT_WIDTH'(STRETCH)) begin
            cnt_next  = cnt_reg + 1'b1;
            irst_next = 1'b0;
        end else begin
            cnt_next  = cnt_reg;
            irst_next = 1'b1;
        end
    end

    // power-on reset also clears the stretch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_reg  <= 3'h7;
            pinLevel_reg <= 1'b1;
            cnt_reg      <= '0;
            irst_reg     <= 1'b0;
        end else if (!powerOnResetN) begin
            cnt_reg  <= '0;
            irst_reg <= 1'b0;
        end else if (clkEn) begin
            rstSync_reg  <= rstSync_next;
            pinLevel_reg <= pinLevel_next;
            cnt_reg      <= cnt_next;
            irst_reg     <= irst_next;
        end
    end
    assign internalResetN = irst_reg;

    // ************************************************************
    // pad drive and input return
    // ************************************************************
    always_comb begin
        port_d_pin_out = portDOut;
        port_d_pin_oe  = portDDir & dGpio;
        port_d_pin_out[PD_DATA_OUT] = dGpio[PD_DATA_OUT] ? portDOut[PD_DATA_OUT] : tdo_reg;
        port_d_pin_oe[PD_DATA_OUT]  = dGpio[PD_DATA_OUT] ? portDDir[PD_DATA_OUT] : drive_reg;
        // reset pin as gpio is open drain: only pulls low
        port_d_pin_out[PD_RESET] = 1'b0;
        port_d_pin_oe[PD_RESET]  = dGpio[PD_RESET] && portDDir[PD_RESET] && !portDOut[PD_RESET];
        port_a_pin_out = portAOut;
        port_a_pin_oe  = portADir & ~aAlt;
        port_a_pin_out[PA_CMP_PIN] = aAlt[PA_CMP_PIN] ? comparator_c_output : portAOut[PA_CMP_PIN];
        port_a_pin_oe[PA_CMP_PIN]  = aAlt[PA_CMP_PIN] ? 1'b1 : portADir[PA_CMP_PIN];
        port_a_pin_oe[PA_REF_PIN]  = aAlt[PA_REF_PIN] ? 1'b0 : portADir[PA_REF_PIN];
    end

    assign portDIn = port_d_pin_in & dGpio;
    assign portAIn = port_a_pin_in;
    // analog path only in alternate mode; the control bit routes it
    assign converter_a_channel2_in = aAlt[PA_REF_PIN] && !converterRefSelect &&
                                     port_a_pin_in[PA_REF_PIN];
    assign converter_a_ref_high    = aAlt[PA_REF_PIN] && converterRefSelect &&
                                     port_a_pin_in[PA_REF_PIN];

    // ************************************************************
    // checks
    // ************************************************************
    tdo_drive_a: assert property (@(posedge testClk) disable iff (!rstn)
        !dGpio[PD_DATA_OUT] |->
        port_d_pin_oe[PD_DATA_OUT] == ((tap_reg == SHIFT_DR) || (tap_reg == SHIFT_IR)))
        else $error("data out driven outside shift");
    cmp_route_a: assert property (@(posedge clk) disable iff (!rstn)
        aAlt[PA_CMP_PIN] |-> port_a_pin_out[PA_CMP_PIN] == comparator_c_output)
        else $error("comparator not routed");
    rst_ignore_a: assert property (@(posedge clk) disable iff (!rstn)
        clkEn && powerOnResetN && dGpio[PD_RESET] && !watchdog_reset_source && !softwareReset
        && irst_reg |=> irst_reg)
        else $error("gpio reset pin caused reset");
    rst_stretch_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(irst_reg) |-> $past(cnt_reg) == RESET_COUNT_WIDTH'(STRETCH))
        else $error("reset released early");
    rst_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        clkEn && powerOnResetN && pinResetReq |=> !irst_reg)
        else $error("pin reset ignored");
    tms_park_a: assert property (@(posedge testClk) disable iff (!rstn)
        dGpio[PD_MODE_SEL] |=> tms_reg)
        else $error("repurposed mode pin not parked");
    alt_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        !portAPeripheralEnable[PA_CMP_PIN] |-> port_a_pin_out[PA_CMP_PIN] == portAOut[PA_CMP_PIN])
        else $error("alternate without enable");
    ref_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        converterRefSelect |-> !converter_a_channel2_in)
        else $error("channel active in reference mode");
endmodule
`default_nettype wire

//--- testbench/test_host_model.sv
// behavioural test host: gated test clock, mode select and data pins
`timescale 1ns/1ps
`default_nettype none
module test_host_model (
    output logic testClk,
    output logic modeSel,
    output logic dataIn
);
    // clock stands low between frames; released pins idle at the pulled-up level
    initial begin
        testClk = 1'b0;
        modeSel = 1'b1;
        dataIn  = 1'b1;
    end
    // one gated 12 ns clock per bit, inputs set half a period before the rise
    task automatic step(input logic m, input logic d);
        modeSel = m;
        dataIn  = d;
        #6 testClk = 1'b1;
        #6 testClk = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/test_port_and_reset_pin_mux_tb_top.sv
// self-checking bench for the test port and reset pin mux
`timescale 1ns/1ps
`default_nettype none
module test_port_and_reset_pin_mux_tb_top;
    import pin_mux_pkg::*;
    localparam int STR = 4;
    logic clk = 1'b0, rstn = 1'b0, wdog = 1'b0, swRst = 1'b0, cmp = 1'b0, refSel = 1'b0;
    logic resetPin = 1'b1, hClk, hMode, hData;
    logic [4:0] dEn = '0, dOut = '0, dDir = '0, dPinOut, dPinOe, dIn;
    logic [9:0] dSel = '0;
    logic [2:0] aEn = '0, aOut = '0, aDir = '0, aPin = '0, aPinOut, aPinOe, aIn;
    logic [5:0] aSel = '0;
    logic       ch2, refHi, tdSample, tmSample, shifting, intRstN, tdRet = 1'b0;
    logic       clkEnable = 1'b1, porN = 1'b1;
    // mode sequences from idle into the two shift states
    logic seqDr [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic seqIr [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [4:0] dPin;
    integer seed = 39, badCount = 0, testsRun = 0, n;
    always #25 clk = ~clk;
    // released data-out pin floats to its pull-up
    assign dPin = {resetPin, hMode, 1'b1, dPinOe[1] ? dPinOut[1] : 1'b1, hData};
    test_host_model u_host (.testClk(hClk), .modeSel(hMode), .dataIn(hData));
    test_port_and_reset_pin_mux #(.STRETCH(STR)) u_dut (
        .clk(clk), .rstn(rstn), .clkEn(clkEnable), .testClk(hClk), .powerOnResetN(porN),
        .watchdog_reset_source(wdog), .softwareReset(swRst), .portDPeripheralEnable(dEn),
        .portDSelect(dSel), .portDOut(dOut), .portDDir(dDir), .portAPeripheralEnable(aEn),
        .portASelect(aSel), .portAOut(aOut), .portADir(aDir), .comparator_c_output(cmp),
        .converterRefSelect(refSel), .testDataReturn(tdRet), .port_d_pin_in(dPin),
        .port_d_pin_out(dPinOut), .port_d_pin_oe(dPinOe), .port_a_pin_in(aPin),
        .port_a_pin_out(aPinOut), .port_a_pin_oe(aPinOe), .portDIn(dIn), .portAIn(aIn),
        .converter_a_channel2_in(ch2), .converter_a_ref_high(refHi),
        .testDataSample(tdSample), .testModeSample(tmSample), .tapShifting(shifting),
        .internalResetN(intRstN));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // alternate function needs both the enable bit and the select code
    function automatic logic altSel(input logic en, input logic [1:0] sel);
        return en && (sel == SELECT_ALT);
    endfunction
    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // waits for the internal reset to lift, bounded, returns the edge count in n
    task automatic waitRelease();
        n = 0;
        while (intRstN !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        #1;
    endtask
    task automatic finishTest();
        $display("tests run %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        badCount++;
        finishTest();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        waitRelease();
        check("reset lifts", intRstN, 1'b1);
        check("data out idle", dPinOe[1], 1'b0);
        check("port a input", aIn, aPin);
        $display("test power reset done");
        @(posedge clk) resetPin <= 1'b0;
        ticks(6);
        check("pin reset held", intRstN, 1'b0);
        @(posedge clk) resetPin <= 1'b1;
        waitRelease();
        // filter plus stretch: no earlier than STR+1 edges, a few filter edges later at most
        check("stretch count", (n >= STR + 1 && n <= STR + 6), 1'b1);
        @(posedge clk) begin
            dEn[PD_RESET] <= 1'b1;
            dSel[9:8] <= SELECT_ALT;
            resetPin <= 1'b0;
        end
        ticks(10);
        check("gpio reset ignored", intRstN, 1'b1);
        @(posedge clk) wdog <= 1'b1;
        ticks(3);
        check("watchdog reset", intRstN, 1'b0);
        @(posedge clk) wdog <= 1'b0;
        waitRelease();
        check("watchdog release", intRstN, 1'b1);
        @(posedge clk) swRst <= 1'b1;
        ticks(3);
        check("software reset", intRstN, 1'b0);
        @(posedge clk) swRst <= 1'b0;
        waitRelease();
        @(posedge clk) porN <= 1'b0;
        ticks(3);
        check("power on reset", intRstN, 1'b0);
        // enable low must hold the stretch counter still
        @(posedge clk) begin
            porN <= 1'b1;
            clkEnable <= 1'b0;
        end
        ticks(10);
        check("frozen stretch", intRstN, 1'b0);
        @(posedge clk) {clkEnable, resetPin, dEn} <= {2'b11, 5'h00};
        waitRelease();
        check("pin release", intRstN, 1'b1);
        $display("test reset pin done");
        repeat (5) u_host.step(1'b1, 1'b1);
        foreach (seqDr[i]) u_host.step(seqDr[i], 1'b1);
        // falling-edge outputs settle after the step returns
        #1;
        check("shift dr flag", {shifting, dPinOe[1]}, 2'b11);
        repeat (4) begin
            n = $random(seed);
            tdRet = n[1];
            u_host.step(1'b0, n[0]);
            #1;
            check("data sample", {tdSample, tmSample}, {n[0], 1'b0});
            check("data out", dPinOut[1], tdRet);
        end
        u_host.step(1'b1, 1'b1);
        #1;
        check("exit releases", {shifting, dPinOe[1]}, 2'b00);
        u_host.step(1'b1, 1'b1);
        u_host.step(1'b0, 1'b1);
        foreach (seqIr[i]) u_host.step(seqIr[i], 1'b1);
        #1;
        check("shift ir drives", dPinOe[1], 1'b1);
        u_host.step(1'b1, 1'b1);
        #1;
        check("ir exit releases", dPinOe[1], 1'b0);
        @(posedge clk) begin
            dEn <= 5'h09;
            dSel <= {2'h0, SELECT_ALT, 4'h0, SELECT_ALT};
        end
        ticks(1);
        u_host.step(1'b0, 1'b0);
        check("repurposed idle", {tdSample, tmSample}, 2'b11);
        $display("test tap done");
        repeat (12) begin
            @(posedge clk) begin
                {cmp, refSel} <= 2'($random(seed));
                aEn <= 3'($random(seed));
                // low select bits of pins 0 and 2 forced so the alternate code comes up often
                aSel <= 6'($random(seed)) | 6'h11;
                aPin <= 3'($random(seed));
                {aOut, aDir} <= 6'($random(seed));
            end
            ticks(1);
            if (altSel(aEn[0], aSel[1:0]))
                check("comparator out", {aPinOe[0], aPinOut[0]}, {1'b1, cmp});
            else
                check("gpio a0", {aPinOe[0], aPinOut[0]}, {aDir[0], aOut[0]});
            check("ref high", refHi,
                  refSel && altSel(aEn[2], aSel[5:4]) && aPin[PA_REF_PIN]);
            check("channel two", ch2,
                  !refSel && altSel(aEn[2], aSel[5:4]) && aPin[PA_REF_PIN]);
        end
        $display("test port a done");
        finishTest();
    end
endmodule
`default_nettype wire
